// ### logic/hspi_top.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] direction high: demodulator on, modulator off
// [RULE2] direction low: modulator on, demodulator off
// [RULE3] host sclk no faster than 12.5 MHz
// [RULE4] sample sdi on sclk fall, 24-bit shifter
// [RULE5] sdo changes on sclk rise, cs low
// [RULE6] sdo tristated until output enable set
// [RULE7] uart break mode: sdo carries irq
// [RULE8] spi-only mode: uart tx carries irq
// [RULE9] cs high: sdo tristate, sdi ignored; code drives sdo with irq in uart break mode when output enable is set
// [RULE10] carrier_detect follows valid carrier presence
// [RULE11] alarm open drain low when asserted
// [RULE12] 24 clocks per frame, act on cs rise
module hspi_top
    import hspi_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sclk,
    input  wire logic        i_csn,
    input  wire logic        i_sdi,
    input  wire logic        i_modem_dir,
    input  wire logic        i_carrier_valid,
    input  wire logic        i_alarm,
    input  wire logic        i_irq,
    input  wire logic        i_uart_tx_data,
    input  wire logic        i_sdo_en_cfg,
    input  wire hspi_mode_t  i_mode,
    input  wire logic [23:0] i_rd_word,
    output logic             o_sdo,
    output logic             o_sdo_oe,
    output logic             o_uart_tx_pin,
    output logic             o_demod_en,
    output logic             o_mod_en,
    output logic             o_carrier_detect,
    output logic             o_alarm_n_o,
    output logic             o_alarm_n_oe,
    output logic [23:0]      o_word,
    output logic             o_word_vld,
    output logic             o_frame_err
);
    hspi_pins_if pins ();

    hspi_sync u_sync
    (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_sclk (i_sclk),
        .i_csn  (i_csn),
        .i_sdi  (i_sdi),
        .pins   (pins)
    );

    logic                  dir_m_r;
    logic                  dir_s_r;
    logic                  cd_m_r;
    logic                  cd_s_r;
    logic                  sclk_d_r;
    logic                  csn_d_r;
    logic [23:0]           shift_r;
    logic [23:0]           shift_nxt;
    logic [23:0]           tx_r;
    logic [HSPI_CNT_W-1:0] cnt_r;
    logic                  sclk_fall;
    logic                  sclk_rise;
    logic                  cs_rise;
    logic                  cs_fall;
    logic                  cs_act;

    assign sclk_fall = sclk_d_r & ~pins.sclk_s;
    assign sclk_rise = ~sclk_d_r & pins.sclk_s;
    assign cs_rise   = ~csn_d_r & pins.csn_s;
    assign cs_fall   = csn_d_r & ~pins.csn_s;
    assign cs_act    = ~pins.csn_s;
    assign shift_nxt = {shift_r[22:0], pins.sdi_s};

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sclk_d_r <= 1'b0;
            csn_d_r  <= 1'b1;
        end
        else
        begin
            sclk_d_r <= pins.sclk_s;
            csn_d_r  <= pins.csn_s;
        end
    end

    // modem direction and carrier pins are asynchronous
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            dir_m_r <= 1'b0;
            dir_s_r <= 1'b0;
            cd_m_r  <= 1'b0;
            cd_s_r  <= 1'b0;
        end
        else
        begin
            dir_m_r <= i_modem_dir;
            dir_s_r <= dir_m_r;
            cd_m_r  <= i_carrier_valid;
            cd_s_r  <= cd_m_r;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_demod_en       <= 1'b0;
            o_mod_en         <= 1'b1;
            o_carrier_detect <= 1'b0;
        end
        else
        begin
            o_demod_en       <= dir_s_r;  // [RULE1]
            o_mod_en         <= ~dir_s_r; // [RULE2]
            o_carrier_detect <= cd_s_r;   // [RULE10]
        end
    end

    // input shifter; sclk assumed within the oversampling budget [RULE3]
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            shift_r <= HSPI_WORD_RST;
            cnt_r   <= HSPI_CNT_RST;
        end
        else if (cs_fall)
        begin
            cnt_r <= HSPI_CNT_RST;
        end
        else if (cs_act && sclk_fall) // [RULE9]
        begin
            shift_r <= shift_nxt; // [RULE4]
            if (cnt_r != HSPI_CNT_FULL)
            begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // word is released only at frame end; short frames are dropped, long frames release the last 24 bits
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_word      <= HSPI_WORD_RST;
            o_word_vld  <= 1'b0;
            o_frame_err <= 1'b0;
        end
        else
        begin
            o_word_vld  <= 1'b0;
            o_frame_err <= 1'b0;
            if (cs_rise)
            begin
                if (cnt_r == HSPI_CNT_FULL && !(sclk_fall))
                begin
                    o_word     <= shift_r; // [RULE12]
                    o_word_vld <= 1'b1;    // [RULE12]
                end
                else
                begin
                    o_frame_err <= 1'b1;
                end
            end
        end
    end

    // readback word loaded at frame start, shifted out on rising sclk
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            tx_r <= HSPI_WORD_RST;
        end
        else if (cs_fall)
        begin
            tx_r <= i_rd_word;
        end
        else if (cs_act && sclk_rise)
        begin
            tx_r <= {tx_r[22:0], 1'b0}; // [RULE5]
        end
    end

    // sdo pin: data while selected, irq in break mode when deselected
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0;
        end
        else if (!i_sdo_en_cfg)
        begin
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0; // [RULE6]
        end
        else if (cs_act)
        begin
            o_sdo    <= tx_r[23]; // [RULE5]
            o_sdo_oe <= 1'b1;
        end
        else if (i_mode == HSPI_MODE_UART_BREAK)
        begin
            o_sdo    <= i_irq; // [RULE7]
            o_sdo_oe <= 1'b1;
        end
        else
        begin
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0; // [RULE9]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_uart_tx_pin <= 1'b1;
        end
        else
        begin
            case (i_mode)
                HSPI_MODE_SPI_ONLY: o_uart_tx_pin <= i_irq; // [RULE8]
                HSPI_MODE_UART:     o_uart_tx_pin <= i_uart_tx_data;
                default:            o_uart_tx_pin <= 1'b1;
            endcase
        end
    end

    // open drain: output value fixed low, enable carries the alarm
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_alarm_n_o  <= 1'b0;
            o_alarm_n_oe <= 1'b0;
        end
        else
        begin
            o_alarm_n_o  <= 1'b0;
            o_alarm_n_oe <= i_alarm; // [RULE11]
        end
    end

    AST_DIR_DEMOD: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
        dir_s_r |=> o_demod_en && !o_mod_en)
        else $error("demodulator not enabled after direction high");

    AST_DIR_MOD: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE2]
        !dir_s_r |=> o_mod_en && !o_demod_en)
        else $error("modulator not enabled after direction low");

    AST_SHIFT_FALL: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE4]
        cs_act && sclk_fall && !cs_fall |=> shift_r[0] == $past(pins.sdi_s))
        else $error("sdi not captured on falling sclk");

    AST_SDO_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE5]
        cs_act && !sclk_rise && !cs_fall |=> $stable(tx_r))
        else $error("output data moved without rising sclk");

    AST_SDO_OFF: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE6]
        !i_sdo_en_cfg |=> !o_sdo_oe)
        else $error("sdo driven while output disabled");

    AST_BREAK_IRQ: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE7]
        i_sdo_en_cfg && !cs_act && i_mode == HSPI_MODE_UART_BREAK |=> o_sdo_oe && o_sdo == $past(i_irq))
        else $error("sdo does not carry irq in break mode");

    AST_TX_IRQ: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE8]
        i_mode == HSPI_MODE_SPI_ONLY |=> o_uart_tx_pin == $past(i_irq))
        else $error("uart tx does not carry irq in spi-only mode");

    AST_CS_HIGH: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE9]
        !cs_act && !cs_fall |=> $stable(shift_r))
        else $error("shifter moved while deselected");

    AST_CD: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE10]
        cd_s_r |=> o_carrier_detect)
        else $error("carrier detect missing");

    AST_ALARM: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE11]
        i_alarm |=> o_alarm_n_oe && !o_alarm_n_o)
        else $error("alarm not pulled low");

    AST_FRAME: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE12]
        o_word_vld |-> $past(cnt_r) == HSPI_CNT_FULL && $past(cs_rise))
        else $error("word released without full frame");

endmodule : hspi_top

// ### logic/hspi_pkg.sv
package hspi_pkg;

    localparam int          HSPI_FRAME_BITS   = 24;
    localparam int          HSPI_CNT_W        = 5;
    localparam int          HSPI_SYNC_STAGES  = 2;
    localparam logic [23:0] HSPI_WORD_RST     = 24'h00_0000;
    localparam logic [4:0]  HSPI_CNT_RST      = 5'h00;
    localparam logic [4:0]  HSPI_CNT_FULL     = 5'h18;
    // host sclk ceiling, mhz; sys clock must sample it at least 10x oversampled
    localparam real         HSPI_SCLK_MAX_MHZ = 12.5;
    localparam real         HSPI_CLK_MHZ      = 125.0;
    localparam int          HSPI_SCLK_MIN_CYC = int'(HSPI_CLK_MHZ / HSPI_SCLK_MAX_MHZ);

    typedef enum logic [1:0]
    {
        HSPI_MODE_SPI_ONLY,
        HSPI_MODE_UART_BREAK,
        HSPI_MODE_UART
    } hspi_mode_t;

endpackage : hspi_pkg

// ### logic/hspi_pins_if.sv
`timescale 1ns/1ps
interface hspi_pins_if;
    logic sclk_s;
    logic csn_s;
    logic sdi_s;
    modport drv (output sclk_s, output csn_s, output sdi_s);
    modport use_ (input sclk_s, input csn_s, input sdi_s);
endinterface : hspi_pins_if

// ### logic/hspi_sync.sv
`timescale 1ns/1ps
module hspi_sync
    import hspi_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_sclk,
    input  wire logic i_csn,
    input  wire logic i_sdi,
    hspi_pins_if.drv  pins
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;

    // first stage feeds only the second
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            // idle levels: csn high, sclk low, sdi high; avoids a false sclk edge after reset
            meta_r <= 3'h5;
            sync_r <= 3'h5;
        end
        else
        begin
            meta_r <= {i_csn, i_sclk, i_sdi};
            sync_r <= meta_r;
        end
    end

    assign pins.csn_s  = sync_r[2];
    assign pins.sclk_s = sync_r[1];
    assign pins.sdi_s  = sync_r[0];
endmodule : hspi_sync

// ### verification/hspi_host_model.sv
`timescale 1ns/1ps
module hspi_host_model
(
    input  wire logic i_sdo,
    output logic      o_sclk,
    output logic      o_csn,
    output logic      o_sdi
);
    initial
    begin
        o_sclk = 1'h0;
        o_csn  = 1'h1;
        o_sdi  = 1'h1;
    end

    // 160 ns sclk period, idle low; sdi moves mid-low so it never races the fall
    task automatic frame(input logic [23:0] w, input int n, input logic sel, output logic [23:0] rx);
        rx    = 24'h00_0000;
        o_csn = ~sel;
        #40;
        for (int k = 0; k < n; k++)
        begin
            #40;
            o_sdi  = w[23 - k];
            #40;
            rx     = {rx[22:0], i_sdo};
            o_sclk = 1'h1;
            #80;
            o_sclk = 1'h0;
        end
        #80;
        o_csn = 1'h1;
        // released line shows the inverse, not a stale bit
        o_sdi = ~o_sdi;
        #80;
    endtask : frame
endmodule : hspi_host_model

// ### verification/test_hspi_top.sv
`timescale 1ns/1ps
module test_hspi_top
    import hspi_pkg::*;
;
    logic        i_clk = 1'h0;
    logic        i_rst = 1'h1;
    wire         sclk, csn, sdi;
    logic        dir = 1'h0, car = 1'h0, alm = 1'h0, irq = 1'h0, utx = 1'h1, cfg = 1'h0;
    hspi_mode_t  mode = HSPI_MODE_SPI_ONLY;
    logic [23:0] rd = 24'hA5_C396;
    logic        sdo, sdo_oe, uart_tx, demod, modu, cd, al_o, al_oe, vld, err;
    logic [23:0] word;
    logic        oe_seen = 1'h0;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) if (sdo_oe === 1'h1) oe_seen <= 1'h1;

    hspi_host_model i_hspi_host_model (.i_sdo(sdo), .o_sclk(sclk), .o_csn(csn), .o_sdi(sdi));

    hspi_top i_hspi_top (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
        .i_modem_dir(dir), .i_carrier_valid(car), .i_alarm(alm), .i_irq(irq), .i_uart_tx_data(utx),
        .i_sdo_en_cfg(cfg), .i_mode(mode), .i_rd_word(rd), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
        .o_uart_tx_pin(uart_tx), .o_demod_en(demod), .o_mod_en(modu), .o_carrier_detect(cd),
        .o_alarm_n_o(al_o), .o_alarm_n_oe(al_oe), .o_word(word), .o_word_vld(vld), .o_frame_err(err));

    task automatic report_and_stop;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // wide enough for flag bits packed above a full word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    task automatic run_frame(input logic [23:0] w, input int n, input logic sel,
                             output logic [23:0] rx, output logic v, output logic e);
        v = 1'h0;
        e = 1'h0;
        fork
            i_hspi_host_model.frame(w, n, sel, rx);
            for (int k = 0; k < 600 && !(v || e); k++)
            begin
                step(1);
                v = vld;
                e = err;
            end
        join
        if (sel && !(v || e))
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : run_frame

    task automatic t_modem;
        for (int d = 0; d < 2; d++)
        begin
            dir = d[0];
            car = d[0];
            alm = d[0];
            step(4);
            chk({demod, modu, cd, al_oe, al_o}, {d[0], ~d[0], d[0], d[0], 1'h0});
        end
    endtask : t_modem

    task automatic t_frames;
        logic [23:0] rx;
        logic        v, e;
        cfg = 1'h0;
        run_frame(24'h55_AA0F, 24, 1'h1, rx, v, e);
        chk(oe_seen, 1'h0);
        cfg = 1'h1;
        run_frame(24'h12_3456, 24, 1'h1, rx, v, e);
        chk(rx, 24'hA5_C396);
        chk({v, e, oe_seen}, 3'h5);
        chk(word, 24'h12_3456);
        step(2);
        chk(sdo_oe, 1'h0);
        run_frame(24'hFF_FFFF, 23, 1'h1, rx, v, e);
        chk({v, e, word}, {2'h1, 24'h12_3456});
        run_frame(24'h00_0F0F, 24, 1'h0, rx, v, e);
        chk({v, e, sdo_oe, word}, {3'h0, 24'h12_3456});
    endtask : t_frames

    task automatic t_irq;
        mode = HSPI_MODE_SPI_ONLY;
        for (int d = 1; d >= 0; d--)
        begin
            irq = d[0];
            step(2);
            chk(uart_tx, d[0]);
        end
        mode = HSPI_MODE_UART_BREAK;
        for (int d = 1; d >= 0; d--)
        begin
            irq = d[0];
            step(2);
            chk({sdo_oe, sdo}, {1'h1, d[0]});
        end
        mode = HSPI_MODE_UART;
        utx  = 1'h0;
        step(2);
        chk(uart_tx, 1'h0);
    endtask : t_irq

    initial
    begin
        step(5);
        i_rst = 1'h0;
        step(4);
        // spi-only mode with irq low: uart tx follows irq, so it reads low
        chk({sdo_oe, uart_tx, demod, modu, cd, al_oe}, 6'h04);
        t_modem();
        t_frames();
        t_irq();
        report_and_stop();
    end
endmodule : test_hspi_top
